// [card_addr_decoder.sv]
// card_addr_decoder: per-channel segment translation and rank decode
// with its descriptor, segment, limit and way registers.
// assumes one clock; config port and requests come from same-clock logic.
`timescale 1ns/1ps

// Contract
// (R1) descriptor holds first logical rank of dimm
// (R2) presence bit 9 marks slot populated
// (R3) bits 8:7 give 4, 8, 16 banks
// (R4) bits 6:5 give 1, 2, 4 ranks
// (R5) bits 4:2 give 2^12 to 2^16 rows
// (R6) bits 1:0 give 2^10 to 2^12 columns
// (R7) eight independent segment rules per channel
// (R8) subtract rule offset from address bits 39:16
// (R9) bits 15:6 pass, memory address from result
// (R10) removed field squeezes out bits 8, 7, 6
// (R11) divide-by-three flag makes 3- or 6-way rules
// (R12) software writes zeros to offset bits 9:0
// (R13) ten-bit limit compared with address 37:28
// (R14) range starts one above previous limit
// (R15) each range owns a fixed way group
// (R16) way offset bits 13:4 are signed
// (R17) page policy picks way by bits 7:6/13:12
// (R18) way rank field: slot high, rank low
// (R19) lowest range with limit not below wins
// (R20) fields reset to zero, reserved reads zero
module card_addr_decoder #(
  parameter int NUM_CHAN = 2,
  parameter int CHAN_W   = 1
) (
  // clock, reset, enable
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              CE_IN,
  // configuration port
  input  wire logic [CHAN_W-1:0] CFG_CHAN_IN,
  input  wire logic [2:0]        CFG_FUNC_IN,
  input  wire logic [7:0]        CFG_ADDR_IN,
  input  wire logic              CFG_WR_IN,
  input  wire logic              CFG_RD_IN,
  input  wire logic [31:0]       CFG_WDATA_IN,
  output logic      [31:0]       CFG_RDATA_OUT,
  output logic                   CFG_RVALID_OUT,
  // page policy
  input  wire logic              CLOSED_PAGE_POLICY_IN,
  // translation request
  input  wire logic              REQ_VALID_IN,
  input  wire logic [CHAN_W-1:0] REQ_CHAN_IN,
  input  wire logic [2:0]        REQ_RULE_IN,
  input  wire logic [39:6]       REQ_ADDR_IN,
  // translation response
  output logic                   RSP_VALID_OUT,
  output logic                   RSP_HIT_OUT,
  output logic      [36:6]       RSP_MADDR_OUT,
  output logic      [2:0]        RSP_RANGE_OUT,
  output logic      [4:0]        RSP_WAY_OUT,
  output logic      [1:0]        RSP_SLOT_OUT,
  output logic      [1:0]        RSP_MODULE_RANK_OUT,
  output logic      [2:0]        RSP_LOGICAL_RANK_OUT,
  output logic      [9:0]        RSP_RANK_OFFSET_OUT,
  output logic                   RSP_PRESENT_OUT,
  output logic      [4:0]        RSP_BANK_BITS_OUT,
  output logic      [1:0]        RSP_RANK_BITS_OUT,
  output logic      [4:0]        RSP_ROW_BITS_OUT,
  output logic      [3:0]        RSP_COL_BITS_OUT
);

  logic [card_pkg::DESC_W-1:0]  desc_q  [NUM_CHAN][card_pkg::NUM_DESC];
  logic [card_pkg::SEG_W-1:0]   seg_q   [NUM_CHAN][card_pkg::NUM_SEG];
  logic [card_pkg::LIMIT_W-1:0] limit_q [NUM_CHAN][card_pkg::NUM_LIMIT];
  logic [card_pkg::WAY_W-1:0]   way_q   [NUM_CHAN][card_pkg::NUM_WAY];
  logic [31:0]       rdata_d;
  logic              desc_hit;
  logic              seg_hit;
  logic              limit_hit;
  logic              way_hit;
  logic [4:0]        cfg_idx;
  logic [card_pkg::SEG_W-1:0] rule;
  logic [37:6]       ma_d;
  logic              v1_q;
  logic [CHAN_W-1:0] chan1_q;
  logic              pol1_q;
  logic [37:6]       ma1_q;
  logic              hit_d;
  logic [2:0]        range_d;
  logic [4:0]        way_d;
  logic [card_pkg::WAY_W-1:0]  way_sel;
  logic [card_pkg::DESC_W-1:0] desc_sel;
  logic [1:0]        slot_d;

  // address falls in a dword window of n entries
  function automatic logic in_win(input logic [7:0] a,
                                  input logic [7:0] base,
                                  input int         n);
    return (int'(a) >= int'(base)) && (int'(a) < int'(base) + 4 * n)
           && (a[1:0] == 2'h0);
  endfunction

  // entry index inside a window
  function automatic logic [4:0] win_idx(input logic [7:0] a,
                                         input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[6:2];
  endfunction

  // config decode
  always_comb begin
    desc_hit  = (CFG_FUNC_IN == card_pkg::FN_SEG) &&
                in_win(CFG_ADDR_IN, card_pkg::DESC_OFF0, card_pkg::NUM_DESC);
    seg_hit   = (CFG_FUNC_IN == card_pkg::FN_SEG) &&
                in_win(CFG_ADDR_IN, card_pkg::SEG_OFF0, card_pkg::NUM_SEG);
    limit_hit = (CFG_FUNC_IN == card_pkg::FN_RANK) &&
                in_win(CFG_ADDR_IN, card_pkg::LIMIT_OFF0, card_pkg::NUM_LIMIT);
    way_hit   = (CFG_FUNC_IN == card_pkg::FN_RANK) &&
                in_win(CFG_ADDR_IN, card_pkg::WAY_OFF0, card_pkg::NUM_WAY);
    cfg_idx = 5'h00;
    if (desc_hit) begin
      cfg_idx = win_idx(CFG_ADDR_IN, card_pkg::DESC_OFF0);
    end else if (seg_hit) begin
      cfg_idx = win_idx(CFG_ADDR_IN, card_pkg::SEG_OFF0);
    end else if (limit_hit) begin
      cfg_idx = win_idx(CFG_ADDR_IN, card_pkg::LIMIT_OFF0);
    end else if (way_hit) begin
      cfg_idx = win_idx(CFG_ADDR_IN, card_pkg::WAY_OFF0);
    end
  end

  // dimm descriptors, reserved bits 31:13 dropped
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        for (int i = 0; i < card_pkg::NUM_DESC; i++) begin
          desc_q[c][i] <= card_pkg::DESC_RST; // (R20)
        end
      end
    end else if (CE_IN && CFG_WR_IN && desc_hit) begin
      desc_q[CFG_CHAN_IN][cfg_idx[1:0]] <=
        CFG_WDATA_IN[card_pkg::DESC_W-1:0]; // (R1)
    end
  end

  // segment rules, offset bits 9:0 held at zero
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        for (int i = 0; i < card_pkg::NUM_SEG; i++) begin
          seg_q[c][i] <= card_pkg::SEG_RST; // (R20)
        end
      end
    end else if (CE_IN && CFG_WR_IN && seg_hit) begin
      seg_q[CFG_CHAN_IN][cfg_idx[2:0]] <=
        {CFG_WDATA_IN[card_pkg::SEG_W-1:card_pkg::SEG_RSVD_W],
         10'h000}; // (R7)
    end
  end

  // rank limits
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        for (int i = 0; i < card_pkg::NUM_LIMIT; i++) begin
          limit_q[c][i] <= card_pkg::LIMIT_RST; // (R20)
        end
      end
    end else if (CE_IN && CFG_WR_IN && limit_hit) begin
      limit_q[CFG_CHAN_IN][cfg_idx[2:0]] <=
        CFG_WDATA_IN[card_pkg::LIMIT_W-1:0]; // (R13)
    end
  end

  // rank interleave ways
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        for (int i = 0; i < card_pkg::NUM_WAY; i++) begin
          way_q[c][i] <= card_pkg::WAY_RST; // (R20)
        end
      end
    end else if (CE_IN && CFG_WR_IN && way_hit) begin
      way_q[CFG_CHAN_IN][cfg_idx] <=
        CFG_WDATA_IN[card_pkg::WAY_W-1:0]; // (R16)
    end
  end

  // read mux, unmapped and reserved bits read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (desc_hit) begin
      rdata_d[card_pkg::DESC_W-1:0] = desc_q[CFG_CHAN_IN][cfg_idx[1:0]];
    end else if (seg_hit) begin
      rdata_d[card_pkg::SEG_W-1:0] = seg_q[CFG_CHAN_IN][cfg_idx[2:0]]; // (R20)
    end else if (limit_hit) begin
      rdata_d[card_pkg::LIMIT_W-1:0] = limit_q[CFG_CHAN_IN][cfg_idx[2:0]];
    end else if (way_hit) begin
      rdata_d[card_pkg::WAY_W-1:0] = way_q[CFG_CHAN_IN][cfg_idx];
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CFG_RDATA_OUT  <= 32'h0000_0000;
      CFG_RVALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      CFG_RVALID_OUT <= CFG_RD_IN;
      if (CFG_RD_IN) begin
        CFG_RDATA_OUT <= rdata_d;
      end
    end
  end

  // stage 1: apply the chosen segment rule
  assign rule = seg_q[REQ_CHAN_IN][REQ_RULE_IN]; // (R7)

  card_seg_xlate u_xlate (
    .sys_addr_in       (REQ_ADDR_IN),
    .offset_in         (rule[card_pkg::SEG_OFF_W-1:0]),
    .removed_in        (rule[card_pkg::SEG_RM_LSB +: 3]),
    .three_way_flag_in (rule[card_pkg::SEG_DIV3_BIT]),
    .mem_addr_out      (ma_d)
  );

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      v1_q    <= 1'b0;
      chan1_q <= '0;
      pol1_q  <= 1'b0;
      ma1_q   <= '0;
    end else if (CE_IN) begin
      v1_q <= REQ_VALID_IN;
      if (REQ_VALID_IN) begin
        chan1_q <= REQ_CHAN_IN;
        pol1_q  <= CLOSED_PAGE_POLICY_IN;
        ma1_q   <= ma_d;
      end
    end
  end

  // stage 2: lowest matching range, then its way
  always_comb begin
    hit_d   = 1'b0;
    range_d = 3'h0;
    for (int i = card_pkg::NUM_LIMIT - 1; i >= 0; i--) begin
      if (limit_q[chan1_q][i] >= ma1_q[37:card_pkg::LIMIT_CMP_LSB]) begin
        hit_d   = 1'b1;   // (R13)
        range_d = 3'(i);  // (R19) (R14)
      end
    end
    way_d = {range_d, pol1_q ? ma1_q[card_pkg::CLOSED_SEL_LSB +: 2]  // (R17)
                             : ma1_q[card_pkg::OPEN_SEL_LSB +: 2]}; // (R15)
    way_sel = way_q[chan1_q][way_d];
    slot_d  = way_sel[card_pkg::WAY_SLOT_LSB +: 2]; // (R18)
    desc_sel = (slot_d < 2'(card_pkg::NUM_DESC)) ?
               desc_q[chan1_q][slot_d] : card_pkg::DESC_RST;
  end

  // response registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RSP_VALID_OUT        <= 1'b0;
      RSP_HIT_OUT          <= 1'b0;
      RSP_MADDR_OUT        <= '0;
      RSP_RANGE_OUT        <= 3'h0;
      RSP_WAY_OUT          <= 5'h00;
      RSP_SLOT_OUT         <= 2'h0;
      RSP_MODULE_RANK_OUT  <= 2'h0;
      RSP_LOGICAL_RANK_OUT <= 3'h0;
      RSP_RANK_OFFSET_OUT  <= 10'h000;
      RSP_PRESENT_OUT      <= 1'b0;
      RSP_BANK_BITS_OUT    <= 5'h00;
      RSP_RANK_BITS_OUT    <= 2'h0;
      RSP_ROW_BITS_OUT     <= 5'h00;
      RSP_COL_BITS_OUT     <= 4'h0;
    end else if (CE_IN) begin
      RSP_VALID_OUT <= v1_q;
      if (v1_q) begin
        RSP_HIT_OUT   <= hit_d;
        RSP_MADDR_OUT <= ma1_q[36:6];
        RSP_RANGE_OUT <= range_d;
        RSP_WAY_OUT   <= way_d;
        RSP_SLOT_OUT  <= slot_d;                                    // (R18)
        RSP_MODULE_RANK_OUT <= way_sel[card_pkg::WAY_RANK_LSB +: 2]; // (R18)
        RSP_LOGICAL_RANK_OUT <= desc_sel[card_pkg::DESC_FIRST_LSB +: 3]
          + {1'b0, way_sel[card_pkg::WAY_RANK_LSB +: 2]};           // (R1)
        RSP_RANK_OFFSET_OUT <= way_sel[card_pkg::WAY_OFF_LSB +: 10]; // (R16)
        RSP_PRESENT_OUT <= desc_sel[card_pkg::DESC_PRES_BIT];       // (R2)
        RSP_BANK_BITS_OUT <= card_pkg::BANK_BITS_BASE
          + {3'h0, desc_sel[card_pkg::DESC_BANK_LSB +: 2]};          // (R3)
        RSP_RANK_BITS_OUT <= desc_sel[card_pkg::DESC_RANK_LSB +: 2]; // (R4)
        RSP_ROW_BITS_OUT <= card_pkg::ROW_BITS_BASE
          + {2'h0, desc_sel[card_pkg::DESC_ROW_LSB +: 3]};           // (R5)
        RSP_COL_BITS_OUT <= card_pkg::COL_BITS_BASE
          + {2'h0, desc_sel[card_pkg::DESC_COL_LSB +: 2]};           // (R6)
      end
    end
  end

  // checks on the two pipeline stages and the config port
  a_rsp_latency: assert property ( // (R7)
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && CE_IN) ##1 CE_IN |=> RSP_VALID_OUT)
    else $error("response did not follow request by two enabled cycles");

  a_read_answer: assert property ( // (R20)
    @(posedge CLK_IN) disable iff (RST_IN)
    CE_IN && CFG_RD_IN && seg_hit |=>
      CFG_RVALID_OUT && CFG_RDATA_OUT[31:28] == 4'h0
      && CFG_RDATA_OUT[9:0] == 10'h000)
    else $error("segment read shows reserved bits set");

  a_offset_sub: assert property ( // (R8)
    @(posedge CLK_IN) disable iff (RST_IN)
    CE_IN && REQ_VALID_IN && rule[27:24] == 4'h0 |=>
      ma1_q[15:6] == $past(REQ_ADDR_IN[15:6])
      && ma1_q[37:16] == 22'($past(REQ_ADDR_IN[37:16]) - $past(rule[21:0])))
    else $error("plain rule did not subtract the offset");

  a_remove_bit6: assert property ( // (R10)
    @(posedge CLK_IN) disable iff (RST_IN)
    CE_IN && REQ_VALID_IN && rule[27:24] == 4'h1 |=>
      ma1_q[14:6] == $past(REQ_ADDR_IN[15:7]))
    else $error("two-way rule did not squeeze out bit 6");

  // line after offset subtraction, before the divide
  logic [33:0] plain_line;
  assign plain_line = {REQ_ADDR_IN[39:16] - rule[23:0], REQ_ADDR_IN[15:6]};
  a_div3_quot: assert property ( // (R11)
    @(posedge CLK_IN) disable iff (RST_IN)
    CE_IN && REQ_VALID_IN && rule[27:24] == 4'h8
      && plain_line[33:32] != 2'b11 |=>
      36'(ma1_q) * 36'h3 <= 36'($past(plain_line))
      && 36'(ma1_q) * 36'h3 + 36'h3 > 36'($past(plain_line)))
    else $error("three-way rule did not divide by three");

  a_range_top: assert property ( // (R13)
    @(posedge CLK_IN) disable iff (RST_IN)
    v1_q && hit_d |->
      limit_q[chan1_q][range_d] >= ma1_q[37:28])
    else $error("chosen range lies below the address");

  a_range_lowest: assert property ( // (R19)
    @(posedge CLK_IN) disable iff (RST_IN)
    v1_q && hit_d && range_d != 3'h0 |->
      limit_q[chan1_q][range_d - 3'h1] < ma1_q[37:28])
    else $error("a lower range also covered the address");

  a_way_pick: assert property ( // (R17)
    @(posedge CLK_IN) disable iff (RST_IN)
    CE_IN && v1_q |=> RSP_WAY_OUT[1:0] ==
      ($past(pol1_q) ? $past(ma1_q[7:6]) : $past(ma1_q[13:12]))
      && RSP_WAY_OUT[4:2] == RSP_RANGE_OUT)
    else $error("way index does not follow page policy");

  c_closed_hit: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    v1_q && hit_d && pol1_q);
  c_top_range: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    v1_q && hit_d && range_d == 3'h7);
  c_no_hit: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    v1_q && !hit_d);
  c_six_way: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    REQ_VALID_IN && rule[27:24] == 4'h9);

endmodule

// [card_pkg.sv]
// card_pkg: register map, field layout and reset values of the
// channel address and rank decoder.
// assumes a dword-aligned configuration port split by function number.
package card_pkg;

  // configuration functions
  localparam logic [2:0] FN_SEG  = 3'h1;  // descriptors and segment rules
  localparam logic [2:0] FN_RANK = 3'h2;  // rank limits and ways

  // register counts per channel
  localparam int NUM_DESC  = 3;
  localparam int NUM_SEG   = 8;
  localparam int NUM_LIMIT = 8;
  localparam int NUM_WAY   = 32;

  // byte offsets of entry 0, one dword per entry
  localparam logic [7:0] DESC_OFF0  = 8'h48;
  localparam logic [7:0] SEG_OFF0   = 8'h80;
  localparam logic [7:0] LIMIT_OFF0 = 8'h40;
  localparam logic [7:0] WAY_OFF0   = 8'h80;

  // dimm descriptor fields
  localparam int DESC_W         = 13;
  localparam int DESC_FIRST_LSB = 10;  // first logical rank, 3 bits
  localparam int DESC_PRES_BIT  = 9;
  localparam int DESC_BANK_LSB  = 7;   // 2 bits
  localparam int DESC_RANK_LSB  = 5;   // 2 bits
  localparam int DESC_ROW_LSB   = 2;   // 3 bits
  localparam int DESC_COL_LSB   = 0;   // 2 bits
  localparam logic [DESC_W-1:0] DESC_RST = 13'h0000;

  // segment rule fields
  localparam int SEG_W        = 28;
  localparam int SEG_DIV3_BIT = 27;
  localparam int SEG_RM_LSB   = 24;    // 3 bits
  localparam int SEG_OFF_W    = 24;
  localparam int SEG_RSVD_W   = 10;    // offset bits 9:0 reserved
  localparam logic [SEG_W-1:0] SEG_RST = 28'h000_0000;

  // rank limit and way fields
  localparam int LIMIT_W = 10;
  localparam logic [LIMIT_W-1:0] LIMIT_RST = 10'h000;
  localparam int LIMIT_CMP_LSB = 28;   // compared against ma[37:28]
  localparam int WAY_W       = 14;
  localparam int WAY_OFF_LSB = 4;      // 10-bit signed offset
  localparam int WAY_SLOT_LSB = 2;     // 2 bits
  localparam int WAY_RANK_LSB = 0;     // 2 bits
  localparam logic [WAY_W-1:0] WAY_RST = 14'h0000;

  // way select bits of the memory address per page policy
  localparam int CLOSED_SEL_LSB = 6;
  localparam int OPEN_SEL_LSB   = 12;

  // geometry base exponents
  localparam logic [4:0] BANK_BITS_BASE = 5'h02;
  localparam logic [4:0] ROW_BITS_BASE  = 5'h0c;
  localparam logic [3:0] COL_BITS_BASE  = 4'ha;

endpackage

// [card_rsp_sink.sv]
// card_rsp_sink: request-path model on the far side of the decoder that
// keeps every translation response with the edge it was seen at.
// assumes the response fields arrive packed into one 74-bit vector.
`timescale 1ns/1ps
module card_rsp_sink (
  // clock
  input  wire logic        clk_in,
  // response from the decoder
  input  wire logic        valid_in,
  input  wire logic [73:0] rsp_in
);
  logic [73:0] rsp_list [$];
  int          cyc_list [$];
  int          cycle = 0;

  // count edges, log each response with its arrival edge
  always @(posedge clk_in) begin
    cycle <= cycle + 1;
    if (valid_in === 1'b1) begin
      rsp_list.push_back(rsp_in);
      cyc_list.push_back(cycle);
    end
  end
endmodule

// [card_seg_xlate.sv]
// card_seg_xlate: one segment rule applied to a system line address,
// giving the channel memory address.
// assumes the caller has picked the rule; purely combinational.
`timescale 1ns/1ps
module card_seg_xlate (
  // system line address and rule
  input  wire logic [39:6] sys_addr_in,
  input  wire logic [23:0] offset_in,
  input  wire logic [2:0]  removed_in,
  input  wire logic        three_way_flag_in,
  // channel memory address
  output logic      [37:6] mem_addr_out
);

  logic [23:0] upper;
  logic [33:0] line;
  logic [33:0] squeezed;

  // drop the flagged bits, highest first so lower positions hold
  function automatic logic [33:0] squeeze(input logic [33:0] x,
                                          input logic [2:0]  rm);
    logic [33:0] r;
    r = x;
    for (int k = 2; k >= 0; k--) begin
      if (rm[k]) begin
        r = ((r >> (k + 1)) << k) | (r & ((34'h1 << k) - 34'h1)); // (R10)
      end
    end
    return r;
  endfunction

  // offset subtraction on bits 39:16, 15:6 pass straight
  always_comb begin
    upper = sys_addr_in[39:16] - offset_in;  // (R8)
    line  = {upper, sys_addr_in[15:6]};      // (R9)
    squeezed = squeeze(line, removed_in);
    if (three_way_flag_in) begin
      squeezed = squeezed / 34'h3;           // (R11)
    end
    mem_addr_out = squeezed[31:0];           // (R9)
  end

endmodule

// [card_tb.sv]
// testbench: self-checking bench of the channel address and rank decoder.
// assumes the decoder's configuration port and one clock at 250 MHz.
`timescale 1ns/1ps
module testbench;
  logic clk, rst, ce, cfg_chan, cfg_wr, cfg_rd, pol, req_valid, req_chan;
  logic [2:0]  cfg_func, req_rule;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata;
  logic [33:0] req_addr;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid, rsp_valid;
  wire  [73:0] rsp;
  int          errors = 0;
  int          compares = 0;
  logic [27:0] seg [8] = '{default: '0};
  logic [9:0]  lim [8] = '{default: '0};
  logic [13:0] way [32] = '{default: '0};
  logic [12:0] dsc [4] = '{default: '0};
  logic [73:0] exq [$];
  int          ecq [$];

  card_addr_decoder dut (
    .CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .CFG_CHAN_IN(cfg_chan), .CFG_FUNC_IN(cfg_func),
    .CFG_ADDR_IN(cfg_addr), .CFG_WR_IN(cfg_wr), .CFG_RD_IN(cfg_rd),
    .CFG_WDATA_IN(cfg_wdata), .CFG_RDATA_OUT(cfg_rdata),
    .CFG_RVALID_OUT(cfg_rvalid), .CLOSED_PAGE_POLICY_IN(pol),
    .REQ_VALID_IN(req_valid), .REQ_CHAN_IN(req_chan),
    .REQ_RULE_IN(req_rule), .REQ_ADDR_IN(req_addr),
    .RSP_VALID_OUT(rsp_valid), .RSP_HIT_OUT(rsp[42]),
    .RSP_MADDR_OUT(rsp[73:43]), .RSP_RANGE_OUT(rsp[41:39]),
    .RSP_WAY_OUT(rsp[38:34]), .RSP_SLOT_OUT(rsp[33:32]),
    .RSP_MODULE_RANK_OUT(rsp[31:30]), .RSP_LOGICAL_RANK_OUT(rsp[29:27]),
    .RSP_RANK_OFFSET_OUT(rsp[26:17]), .RSP_PRESENT_OUT(rsp[16]),
    .RSP_BANK_BITS_OUT(rsp[15:11]), .RSP_RANK_BITS_OUT(rsp[10:9]),
    .RSP_ROW_BITS_OUT(rsp[8:4]), .RSP_COL_BITS_OUT(rsp[3:0])
  );

  card_rsp_sink sink (.clk_in(clk), .valid_in(rsp_valid), .rsp_in(rsp));

  // expected response from the register mirrors
  function automatic logic [73:0] model(logic [33:0] sl, logic [27:0] sg,
                                        logic pl);
    logic [33:0] v;
    logic [3:0]  r;
    logic [4:0]  w;
    logic [13:0] wy;
    logic [12:0] d;
    v = {sl[33:10] - sg[23:0], sl[9:0]};
    v = v >> ((sg[26:24] == 3'h3) ? 2 : sg[24]);
    if (sg[27])
      v = v / 3;
    r = 4'h8;
    for (int i = 7; i >= 0; i--)
      if (lim[i] >= v[31:22])
        r = 4'(i);
    w = {r[2:0], pl ? v[1:0] : v[7:6]};
    wy = way[w];
    d = dsc[wy[3:2]];
    return {v[30:0], ~r[3], r[2:0], w, wy[3:0], d[12:10] + wy[1:0],
            wy[13:4], d[9], 5'h02 + d[8:7], d[6:5], 5'h0c + d[4:2],
            4'ha + d[1:0]};
  endfunction

  task automatic chk(string n, logic [73:0] s, logic [73:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(logic ch, logic [2:0] fn, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    cfg_chan <= ch;
    cfg_func <= fn;
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic rdc(logic ch, logic [2:0] fn, logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    cfg_chan <= ch;
    cfg_func <= fn;
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk("config read", {cfg_rvalid, cfg_rdata}, {1'b1, e});
  endtask

  task automatic set_lim(int i, logic [9:0] v);
    lim[i] = v;
    wr(1'b0, card_pkg::FN_RANK, 8'(card_pkg::LIMIT_OFF0 + 4 * i), 32'(v));
  endtask

  task automatic set_way(int i, logic [13:0] v);
    way[i] = v;
    wr(1'b0, card_pkg::FN_RANK, 8'(card_pkg::WAY_OFF0 + 4 * i), 32'(v));
  endtask

  task automatic set_desc(int i, logic [12:0] v);
    dsc[i] = v;
    wr(1'b0, card_pkg::FN_SEG, 8'(card_pkg::DESC_OFF0 + 4 * i), 32'(v));
  endtask

  // one request per call; valid stays up for back-to-back trains
  task automatic req(logic [2:0] rl, logic [33:0] sl, logic pl, int gap);
    @(posedge clk);
    req_valid <= 1'b1;
    req_rule <= rl;
    req_addr <= sl;
    pol <= pl;
    exq.push_back(model(sl, seg[rl], pl));
    ecq.push_back(sink.cycle + 3 + gap);
  endtask

  task automatic drain();
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("response count", 74'(sink.rsp_list.size()), 74'(exq.size()));
    while (exq.size() > 0 && sink.rsp_list.size() > 0) begin
      chk("response", sink.rsp_list.pop_front(),
          exq.pop_front());
      chk("response edge", 74'(sink.cyc_list.pop_front()),
          74'(ecq.pop_front()));
    end
    exq.delete();
    ecq.delete();
  endtask

  // reset values, reserved bits, unmapped places, channel separation
  task automatic t_regs();
    logic [2:0]  fn [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h2};
    logic [7:0]  ad [6] = '{8'h48, 8'h9c, 8'h5c, 8'hfc, 8'h00, 8'h42};
    logic [31:0] mk [6] = '{32'h0000_1fff, 32'h0fff_fc00, 32'h0000_03ff,
                            32'h0000_3fff, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 6; i++) begin
      rdc(1'b0, fn[i], ad[i], 32'h0000_0000);
      wr(1'b1, fn[i], ad[i], 32'hffff_ffff);
      rdc(1'b1, fn[i], ad[i], mk[i]);
      rdc(1'b0, fn[i], ad[i], 32'h0000_0000);
      wr(1'b1, fn[i], ad[i], 32'h0000_0000);
    end
  endtask

  // every legal removed/flag pair, each in its own rule, back to back
  task automatic t_seg();
    logic [27:0] sg [5] = '{28'h000_0c00, 28'h100_0c00, 28'h300_0c00,
                            28'h800_0c00, 28'h900_0c00};
    for (int k = 0; k < 5; k++) begin
      seg[k + 1] = sg[k];
      wr(1'b0, card_pkg::FN_SEG, 8'(card_pkg::SEG_OFF0 + 4 * (k + 1)),
         32'(sg[k]));
    end
    for (int k = 0; k < 6; k++)
      req(3'(k), 34'h1_2345_6789, 1'b1, 0);
    drain();
  endtask

  // range tiling, way groups, both page policies, a miss
  task automatic t_rank();
    logic [9:0] hs [8] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h00d,
                           10'h00e, 10'h3f0, 10'h3f5};
    for (int i = 0; i < 8; i++)
      set_lim(i, (i == 7) ? 10'h3f0 : 10'(2 * i + 1));
    for (int i = 0; i < 32; i++)
      set_way(i, {10'(i * 45 + 600), 4'(i)});
    for (int s = 0; s < 3; s++)
      set_desc(s, {3'(2 * s), 1'b1, 2'(s), 2'(s), 3'(s + 2), 2'(s)});
    for (int i = 0; i < 8; i++)
      for (int p = 0; p < 2; p++)
        req(3'h0, {2'b00, hs[i], 14'h0000, 2'(i), 4'h0, 2'(i + 1)},
            1'(p), 0);
    drain();
  endtask

  // bank, rank and column codes 00 to 10 and row codes 0 to 4; code 11 is never programmed
  task automatic t_geom();
    for (int r = 0; r < 5; r++) begin
      set_desc(0, {3'(r), 1'(r), 2'(r % 3), 2'(r % 3), 3'(r),
                   2'(r % 3)});
      req(3'h0, {26'h000_0000, 2'(r), 6'h00}, 1'b0, 0);
      @(posedge clk);
      req_valid <= 1'b0;
    end
    drain();
  endtask

  // clock enable low for one cycle delays the answer by one edge
  task automatic t_hold();
    req(3'h2, 34'h0_0040_0100, 1'b1, 1);
    @(posedge clk);
    req_valid <= 1'b0;
    ce <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    drain();
  endtask

  // second reset in mid-run clears the registers
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdc(1'b0, card_pkg::FN_RANK, 8'h40, 32'h0000_0000);
    rdc(1'b0, card_pkg::FN_SEG, 8'h48, 32'h0000_0000);
  endtask

  // a limit on channel 1 steers only requests of channel 1
  task automatic t_chan();
    seg = '{default: '0};
    lim = '{default: '0};
    way = '{default: '0};
    dsc = '{default: '0};
    lim[0] = 10'h3ff;
    wr(1'b1, card_pkg::FN_RANK, card_pkg::LIMIT_OFF0, 32'h0000_03ff);
    rdc(1'b0, card_pkg::FN_RANK, card_pkg::LIMIT_OFF0, 32'h0000_0000);
    req_chan <= 1'b1;
    req(3'h0, 34'h0_0040_0000, 1'b1, 0);
    drain();
    req_chan <= 1'b0;
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {cfg_chan, cfg_wr, cfg_rd, pol, req_valid, req_chan} = 6'h00;
    cfg_func = 3'h0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0000_0000;
    req_rule = 3'h0;
    req_addr = 34'h0_0000_0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_seg();
    t_rank();
    t_geom();
    t_hold();
    t_reset();
    t_chan();
    summarize();
  end

  // watchdog against a hang
  initial begin
    #100000;
    errors++;
    summarize();
  end
endmodule
